// ### hdl/packet_packet_lines_a_codec.sv
// Purpose: Encoder and decoder of the six packet specification lines
// Assumes: One bus clock; lines and AD sampled synchronously
// Notes:   Transmit words come from a 16-word FIFO, received ones go
//          to another; software reaches both through the registers
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "packet_packet_lines_a_consts.svh"
module packet_packet_lines_a_codec (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic [31:0]      reg_rdata,
   input  wire logic [5:0]  packet_lines_a_n_rx,
   output logic [5:0]       packet_lines_a_n_tx,
   output logic             packet_lines_a_oe,
   input  wire logic [31:0] addr_data_rx,
   output logic [31:0]      addr_data_tx,
   output logic             addr_data_oe
);
   import packet_packet_lines_a_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [1:0]  ctrl;
   logic [1:0]  next_ctrl;
   logic [31:0] tx_addr;
   logic [31:0] next_tx_addr;
   logic [3:0]  tx_marks;
   logic [3:0]  next_tx_marks;
   logic [4:0]  err;
   logic [4:0]  next_err;
   logic [31:0] next_rdata;
   logic [3:0]  seen_marks;
   logic [3:0]  next_seen_marks;
   tx_state_t   tx_state;
   tx_state_t   next_tx_state;
   logic [5:0]  tx_code;
   logic [5:0]  next_tx_code;
   logic [2:0]  tx_left;
   logic [2:0]  next_tx_left;
   logic [5:0]  next_lines_n;
   logic        next_lines_oe;
   logic [31:0] next_ad_tx;
   logic        next_ad_oe;
   logic        first_mark;
   logic        next_first;
   rx_state_t   rx_state;
   rx_state_t   next_rx_state;
   logic [5:0]  rx_last;
   logic [5:0]  next_rx_last;
   logic [31:0] rx_addr;
   logic [31:0] next_rx_addr;
   logic [2:0]  rx_left;
   logic [2:0]  next_rx_left;
   logic [5:0]  cur_code;
   logic [5:0]  rx_code;
   packet_lines_a_info_t  info_cur;
   packet_lines_a_info_t  info_rx;
   packet_lines_a_info_t  info_tx;
   logic        cmd_wr;
   logic        launch;
   logic        misalign;
   logic        go_first;
   logic        set_res;
   logic        set_mark;
   word_t       txf_in;
   word_t       txf_head;
   logic        txf_push;
   logic        txf_ready;
   logic        txf_valid;
   logic        txf_pop;
   logic [4:0]  txf_count;
   word_t       rxf_in;
   word_t       rxf_head;
   logic        rxf_push;
   logic        rxf_ready;
   logic        rxf_valid;
   logic        rxf_pop;
   logic [4:0]  rxf_count;

   // ----------------------------------------
   // Code lookups and data buffers
   // ----------------------------------------
   assign cur_code = (tx_state == TX_IDLE) ? reg_wdata[5:0] : tx_code;
   assign rx_code  = ~packet_lines_a_n_rx;

   packet_lines_a_code_lookup u_cur (.code(cur_code), .info(info_cur));
   packet_lines_a_code_lookup u_rx (.code(rx_code), .info(info_rx));
   packet_lines_a_code_lookup u_tx (.code(~packet_lines_a_n_tx), .info(info_tx));

   word_fifo #(.WIDTH(36), .DEPTH(`FIFO_DEPTH)) u_txf (
      .clock     (clock),
      .rst       (rst),
      .in_data   (txf_in),
      .in_valid  (txf_push),
      .in_ready  (txf_ready),
      .out_data  (txf_head),
      .out_valid (txf_valid),
      .out_ready (txf_pop),
      .count     (txf_count)
   );

   word_fifo #(.WIDTH(36), .DEPTH(`FIFO_DEPTH)) u_rxf (
      .clock     (clock),
      .rst       (rst),
      .in_data   (rxf_in),
      .in_valid  (rxf_push),
      .in_ready  (rxf_ready),
      .out_data  (rxf_head),
      .out_valid (rxf_valid),
      .out_ready (rxf_pop),
      .count     (rxf_count)
   );

   // ----------------------------------------
   // Encoder
   // ----------------------------------------
   assign cmd_wr = reg_write && (reg_addr == `REG_TX_CMD);
   // Launch only legal codes with all their data words buffered
   assign launch = cmd_wr && (tx_state == TX_IDLE) && ctrl[`CTRL_EN]
                   && info_cur.valid && (txf_count >= {2'h0, info_cur.words});
   assign misalign = ctrl[`CTRL_ALIGN] && (tx_addr[1:0] != 2'h0)
                     && (info_cur.words > 3'h1);

   always_comb begin
      next_tx_state = tx_state;
      next_tx_code  = tx_code;
      next_tx_left  = tx_left;
      next_lines_n  = `LINES_IDLE_N;
      next_lines_oe = 1'b0;
      next_ad_tx    = 32'h0000_0000;
      next_ad_oe    = 1'b0;
      next_first    = 1'b0;
      txf_pop       = 1'b0;
      go_first      = 1'b0;
      case (tx_state)
         TX_IDLE: begin
            if (launch) begin
               next_tx_code = reg_wdata[5:0];
               if (misalign) begin
                  next_tx_state = TX_ALIGN;
               end else begin
                  go_first = 1'b1;
               end
            end
         end
         TX_ALIGN: begin
            go_first = 1'b1;
         end
         TX_DATA: begin
            txf_pop       = 1'b1;
            next_lines_oe = 1'b1;
            next_ad_oe    = 1'b1;
            next_ad_tx    = txf_head.data;
            if (tx_code[5]) begin
               next_lines_n = {1'b1, ~txf_head.marks, 1'b1};
            end else begin
               next_lines_n = `RD_MARK_N;
            end
            next_tx_left = tx_left - 3'h1;
            if (tx_left == 3'h1) begin
               next_tx_state = TX_IDLE;
            end
         end
         default: next_tx_state = TX_IDLE;
      endcase
      if (go_first) begin
         next_lines_oe = 1'b1;
         next_ad_oe    = 1'b1;
         next_first    = 1'b1;
         next_lines_n  = ~cur_code;
         next_ad_tx    = tx_addr;
         next_tx_left  = info_cur.words;
         if (info_cur.rd_reply) begin
            txf_pop      = 1'b1;
            next_ad_tx   = txf_head.data;
            next_tx_left = info_cur.words - 3'h1;
         end
         next_tx_state = (next_tx_left != 3'h0) ? TX_DATA : TX_IDLE;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_state            <= TX_IDLE;
         tx_code             <= 6'h00;
         tx_left             <= 3'h0;
         packet_lines_a_n_tx <= `LINES_IDLE_N;
         packet_lines_a_oe   <= 1'b0;
         addr_data_tx        <= 32'h0000_0000;
         addr_data_oe        <= 1'b0;
         first_mark          <= 1'b0;
      end else begin
         tx_state            <= next_tx_state;
         tx_code             <= next_tx_code;
         tx_left             <= next_tx_left;
         packet_lines_a_n_tx <= next_lines_n;
         packet_lines_a_oe   <= next_lines_oe;
         addr_data_tx        <= next_ad_tx;
         addr_data_oe        <= next_ad_oe;
         first_mark          <= next_first;
      end
   end

   // ----------------------------------------
   // Decoder
   // ----------------------------------------
   always_comb begin
      next_rx_state = rx_state;
      next_rx_last  = rx_last;
      next_rx_addr  = rx_addr;
      next_rx_left  = rx_left;
      rxf_push      = 1'b0;
      rxf_in        = '0;
      set_res       = 1'b0;
      set_mark      = 1'b0;
      if (ctrl[`CTRL_EN] && !packet_lines_a_oe) begin
         case (rx_state)
            RX_IDLE: begin
               if (rx_code != 6'h00) begin
                  if (!info_rx.valid) begin
                     set_res = 1'b1;
                  end else begin
                     next_rx_last = rx_code;
                     next_rx_left = info_rx.cycles - 3'h1;
                     if (info_rx.is_req) begin
                        next_rx_addr = addr_data_rx;
                     end
                     if (info_rx.rd_reply) begin
                        rxf_push = 1'b1;
                        rxf_in   = {addr_data_rx, 4'hF};
                     end
                     if (info_rx.cycles > 3'h1) begin
                        next_rx_state = RX_DATA;
                     end
                  end
               end
            end
            RX_DATA: begin
               rxf_push = 1'b1;
               if (rx_last[5]) begin
                  rxf_in = {addr_data_rx, rx_code[4:1]};
               end else begin
                  rxf_in   = {addr_data_rx, 4'hF};
                  set_mark = !(rx_code[4] && rx_code[1]);
               end
               next_rx_left = rx_left - 3'h1;
               if (rx_left == 3'h1) begin
                  next_rx_state = RX_IDLE;
               end
            end
            default: next_rx_state = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_state <= RX_IDLE;
         rx_last  <= 6'h00;
         rx_addr  <= 32'h0000_0000;
         rx_left  <= 3'h0;
      end else begin
         rx_state <= next_rx_state;
         rx_last  <= next_rx_last;
         rx_addr  <= next_rx_addr;
         rx_left  <= next_rx_left;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   assign txf_push = reg_write && (reg_addr == `REG_TX_DATA);
   assign txf_in   = {reg_wdata, tx_marks};
   assign rxf_pop  = reg_read && (reg_addr == `REG_RX_DATA);

   always_comb begin
      next_ctrl       = ctrl;
      next_tx_addr    = tx_addr;
      next_tx_marks   = tx_marks;
      next_seen_marks = seen_marks;
      next_rdata      = 32'h0000_0000;
      next_err        = err;
      if (reg_write) begin
         case (reg_addr)
            `REG_CTRL:     next_ctrl = reg_wdata[1:0];
            `REG_STATUS:   next_err = err & ~reg_wdata[4:0];
            `REG_TX_ADDR:  next_tx_addr = reg_wdata;
            `REG_TX_MARKS: next_tx_marks = reg_wdata[3:0];
            default:       next_ctrl = ctrl;
         endcase
      end
      // Hardware set wins over a same-cycle clear
      next_err = next_err | {rxf_push && !rxf_ready, txf_push && !txf_ready,
                             set_mark, set_res, cmd_wr && !launch};
      if (reg_read) begin
         case (reg_addr)
            `REG_CTRL:   next_rdata[1:0] = ctrl;
            `REG_STATUS: begin
               next_rdata[4:0]             = err;
               next_rdata[`ST_BUSY]        = (tx_state != TX_IDLE);
               next_rdata[`ST_TXF_FULL]    = !txf_ready;
               next_rdata[`ST_RXF_EMPTY]   = !rxf_valid;
               next_rdata[`ST_CNT_LSB+:5]  = txf_count;
            end
            `REG_TX_ADDR:  next_rdata = tx_addr;
            `REG_TX_MARKS: next_rdata[3:0] = tx_marks;
            `REG_RX_HEAD: begin
               next_rdata[5:0]             = rx_last;
               next_rdata[`HEAD_MARKS+:4]  = seen_marks;
               next_rdata[`ST_CNT_LSB+:5]  = rxf_count;
            end
            `REG_RX_ADDR: next_rdata = rx_addr;
            `REG_RX_DATA: begin
               next_rdata      = rxf_valid ? rxf_head.data : 32'h0000_0000;
               next_seen_marks = rxf_valid ? rxf_head.marks : seen_marks;
            end
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl       <= `CTRL_RST;
         tx_addr    <= 32'h0000_0000;
         tx_marks   <= `MARKS_RST;
         err        <= 5'h00;
         reg_rdata  <= 32'h0000_0000;
         seen_marks <= 4'h0;
      end else begin
         ctrl       <= next_ctrl;
         tx_addr    <= next_tx_addr;
         tx_marks   <= next_tx_marks;
         err        <= next_err;
         reg_rdata  <= next_rdata;
         seen_marks <= next_seen_marks;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_TX_CODE_LEGAL: assert property (@(posedge clock) disable iff (rst)
      first_mark |-> info_tx.valid)
      else $error("Undefined code driven in first cycle");

   AST_TX_ACTIVE_LOW: assert property (@(posedge clock) disable iff (rst)
      (launch && !misalign) |=> packet_lines_a_oe
         && (packet_lines_a_n_tx == ~$past(reg_wdata[5:0])))
      else $error("First-cycle lines not the inverted code");

   AST_REQ_TOP_LINE: assert property (@(posedge clock) disable iff (rst)
      first_mark |-> (packet_lines_a_n_tx[5] == !info_tx.is_req))
      else $error("Top line does not mark packet type");

   AST_WRITE_LENGTH: assert property (@(posedge clock) disable iff (rst)
      (first_mark && info_tx.is_write && info_tx.cycles == 3'h5)
      |-> packet_lines_a_oe [*5] ##1 (!packet_lines_a_oe || first_mark))
      else $error("Four-word write not five cycles");

   AST_READ_REQ_ONE: assert property (@(posedge clock) disable iff (rst)
      (first_mark && info_tx.is_req && !info_tx.is_write)
      |=> (!packet_lines_a_oe || first_mark))
      else $error("Read request longer than one cycle");

   AST_WRITE_MARKS: assert property (@(posedge clock) disable iff (rst)
      (packet_lines_a_oe && !first_mark && tx_code[5])
      |-> (packet_lines_a_n_tx[5] && packet_lines_a_n_tx[0]
           && packet_lines_a_n_tx[4:1] == ~$past(txf_head.marks)))
      else $error("Write data cycle marks wrong");

   AST_READ_DATA_MARK: assert property (@(posedge clock) disable iff (rst)
      (packet_lines_a_oe && !first_mark && !tx_code[5])
      |-> (!packet_lines_a_n_tx[4] && !packet_lines_a_n_tx[1] && packet_lines_a_n_tx[5]))
      else $error("Read data cycle does not assert lines 4 and 1");

   AST_RX_RESERVED: assert property (@(posedge clock) disable iff (rst)
      set_res |=> err[1] && (rx_last == $past(rx_last)) && (rx_state == RX_IDLE))
      else $error("Reserved code acted upon");

   AST_LAUNCH_REFUSED: assert property (@(posedge clock) disable iff (rst)
      (cmd_wr && !launch) |=> err[0]
         && ($past(tx_state) != TX_IDLE || (tx_state == TX_IDLE && !first_mark)))
      else $error("Refused launch not flagged");

   COV_WRITE4: cover property (@(posedge clock) disable iff (rst)
      first_mark && info_tx.is_write && info_tx.cycles == 3'h5);
   COV_READ_REPLY: cover property (@(posedge clock) disable iff (rst)
      first_mark && info_tx.rd_reply && info_tx.words == 3'h4);
   COV_ALIGN: cover property (@(posedge clock) disable iff (rst)
      tx_state == TX_ALIGN);
   COV_RX_RESERVED: cover property (@(posedge clock) disable iff (rst) set_res);
endmodule

// ### hdl/packet_packet_lines_a_consts.svh
// Purpose: Offsets, field positions, reset values and codes of the codec
// Assumes: 32-bit register data, byte addresses
// Notes:   Codes are logical; a one is an asserted (low) line
`ifndef PACKET_PACKET_LINES_A_CONSTS_SVH
`define PACKET_PACKET_LINES_A_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL     8'h00
`define REG_STATUS   8'h04
`define REG_TX_CMD   8'h08
`define REG_TX_ADDR  8'h0C
`define REG_TX_DATA  8'h10
`define REG_TX_MARKS 8'h14
`define REG_RX_HEAD  8'h18
`define REG_RX_ADDR  8'h1C
`define REG_RX_DATA  8'h20
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_EN      0
`define CTRL_ALIGN   1
`define CTRL_RST     2'h1
`define MARKS_RST    4'hF
`define ST_BUSY      8
`define ST_TXF_FULL  9
`define ST_RXF_EMPTY 10
`define ST_CNT_LSB   16
`define HEAD_MARKS   8
// ----------------------------------------
// First-cycle codes
// ----------------------------------------
`define C_RD1  6'h20
`define C_RD2  6'h24
`define C_RD3  6'h28
`define C_RD4  6'h2C
`define C_RM1  6'h21
`define C_RM2  6'h25
`define C_RM3  6'h29
`define C_RM4  6'h2D
`define C_RDB  6'h22
`define C_RDD  6'h23
`define C_WR1  6'h30
`define C_WR2  6'h34
`define C_WR3  6'h38
`define C_WR4  6'h3C
`define C_WM1  6'h31
`define C_WM2  6'h35
`define C_WM3  6'h39
`define C_WM4  6'h3D
`define C_RR1  6'h06
`define C_RR2  6'h12
`define C_RR3  6'h16
`define C_RR4  6'h1A
`define C_WACK 6'h02
`define C_REIS 6'h0F
`define C_NACK 6'h0A
`define C_BAD  6'h0B
// Read data cycles: lines 4 and 1 low, rest high
`define RD_MARK_N 6'h2D
`define LINES_IDLE_N 6'h3F
`define FIFO_DEPTH 16
`endif

// ### hdl/packet_packet_lines_a_pkg.sv
// Purpose: Types shared by the codec files
// Assumes: Nothing
// Notes:   Word entries carry data with byte marks
package packet_packet_lines_a_pkg;
   typedef struct packed {
      logic       valid;
      logic       is_req;
      logic       is_write;
      logic       rd_reply;
      logic [2:0] cycles;
      logic [2:0] words;
   } packet_lines_a_info_t;
   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  marks;
   } word_t;
   typedef enum logic [1:0] {TX_IDLE, TX_ALIGN, TX_DATA} tx_state_t;
   typedef enum logic {RX_IDLE, RX_DATA} rx_state_t;
endpackage

// ### hdl/packet_lines_a_code_lookup.sv
// Purpose: Decode a first-cycle code into kind, length and data words
// Assumes: Code given as logical value (one = asserted)
// Notes:   Undefined codes give valid low
`timescale 1ns/1ps
`include "packet_packet_lines_a_consts.svh"
module packet_lines_a_code_lookup (
   input  wire logic [5:0]                code,
   output packet_packet_lines_a_pkg::packet_lines_a_info_t    info
);
   import packet_packet_lines_a_pkg::*;
   always_comb begin
      info = '0;
      case (code)
         `C_RD1, `C_RD2, `C_RD3, `C_RD4, `C_RM1, `C_RM2, `C_RM3, `C_RM4,
         `C_RDB, `C_RDD: begin
            info.valid  = 1'b1;
            info.is_req = 1'b1;
            info.cycles = 3'h1;
         end
         `C_WR1, `C_WR2, `C_WR3, `C_WR4, `C_WM1, `C_WM2, `C_WM3, `C_WM4: begin
            info.valid    = 1'b1;
            info.is_req   = 1'b1;
            info.is_write = 1'b1;
            info.words    = {1'b0, code[3:2]} + 3'h1;
            info.cycles   = {1'b0, code[3:2]} + 3'h2;
         end
         `C_RR1, `C_RR2, `C_RR3, `C_RR4: begin
            info.valid    = 1'b1;
            info.rd_reply = 1'b1;
            info.words    = (code == `C_RR1) ? 3'h1 : {1'b0, code[3:2]} + 3'h2;
            info.cycles   = info.words;
         end
         `C_WACK, `C_REIS, `C_NACK, `C_BAD: begin
            info.valid  = 1'b1;
            info.cycles = 3'h1;
         end
         default: info = '0;
      endcase
   end
endmodule

// ### hdl/word_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Head word is shown while out_valid is high
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   input  wire logic                       clock,
   input  wire logic                       rst,
   input  wire logic [WIDTH-1:0]           in_data,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [$clog2(DEPTH):0]          count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wp;
   logic [AW-1:0]    rp;
   logic             push;
   logic             pop;
   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data  = store[rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wp    <= '0;
         rp    <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
   always_ff @(posedge clock) begin
      if (push) begin
         store[wp] <= in_data;
      end
   end
endmodule

// ### tb/bus_agent_model.sv
// Purpose: Far-side bus agent that plays one packet onto the lines
// Assumes: Bench asks for a reserved code only where it means to
// Notes:   Released lines float high; released AD shows the inverse
`timescale 1ns/1ps
module bus_agent_model (
   input  wire logic             clock,
   input  wire logic             go,
   input  wire logic [5:0]       code,
   input  wire logic [3:0]       marks,
   input  wire logic [2:0]       len,
   input  wire logic [4:0][31:0] ad_seq,
   output logic [5:0]            lines_n,
   output logic [31:0]           ad
);
   initial begin
      lines_n = 6'h3F;
      ad = 32'h0000_0000;
   end
   always @(posedge clock) begin
      if (go) begin
         for (int i = 0; i < len; i++) begin
            lines_n <= (i == 0) ? ~code
               : (code[5:4] == 2'h3) ? {1'b1, ~marks, 1'b1}
               : 6'h2D;
            ad <= ad_seq[i];
            @(posedge clock);
         end
         lines_n <= 6'h3F;
         ad <= ~ad;
      end
   end
endmodule

// ### tb/packet_packet_lines_a_codec_tb.sv
// Purpose: Self-checking bench of the packet codec
// Assumes: Aligned addresses, so no realign cycle, except in the one realign test
// Notes:   Random data from a fixed seed
`timescale 1ns/1ps
`include "packet_packet_lines_a_consts.svh"
module packet_packet_lines_a_codec_tb;
   logic clock, rst, reg_write, reg_read, go, lines_oe, ad_oe;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, ad_tx, ad_w, p_ad, rv, addr;
   logic [5:0]  lines_tx, lines_w, p_lines, p_code, code;
   logic [3:0]  p_marks, m;
   logic [2:0]  p_len;
   logic [4:0][31:0] p_seq;
   logic [31:0] w [4];
   int num_errors, check_count, seed, n;
   localparam logic [5:0] CODES [26] = '{6'h20, 6'h24, 6'h28, 6'h2C, 6'h21, 6'h25,
      6'h29, 6'h2D, 6'h22, 6'h23, 6'h30, 6'h34, 6'h38, 6'h3C, 6'h31, 6'h35, 6'h39,
      6'h3D, 6'h06, 6'h12, 6'h16, 6'h1A, 6'h02, 6'h0F, 6'h0A, 6'h0B};
   assign lines_w = (lines_oe ? lines_tx : 6'h3F) & p_lines;
   assign ad_w = ad_oe ? ad_tx : p_ad;
   packet_packet_lines_a_codec dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .packet_lines_a_n_rx(lines_w),
      .packet_lines_a_n_tx(lines_tx), .packet_lines_a_oe(lines_oe),
      .addr_data_rx(ad_w), .addr_data_tx(ad_tx), .addr_data_oe(ad_oe));
   bus_agent_model far_agent (.clock(clock), .go(go), .code(p_code), .marks(p_marks),
      .len(p_len), .ad_seq(p_seq), .lines_n(p_lines), .ad(p_ad));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic int nwords(input logic [5:0] c);
      if (c[5:4] == 2'h3) return c[3:2] + 1;
      return (c == 6'h06) + 2 * (c == 6'h12) + 3 * (c == 6'h16) + 4 * (c == 6'h1A);
   endfunction
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic chk_pkt(input logic [5:0] c, input int k);
      logic [31:0] e_ad;
      logic [5:0]  e_ln;
      int len;
      len = (c[5:4] == 2'h3) ? k + 1 : ((k > 1) ? k : 1);
      for (int i = 0; i < len; i++) begin
         #1;
         e_ln = (i == 0) ? ~c : (c[5:4] == 2'h3) ? {1'b1, ~m, 1'b1} : 6'h2D;
         e_ad = (i == 0 && (c[5] || k == 0)) ? addr : w[c[5] ? i - 1 : i];
         cmp(lines_tx, e_ln);
         cmp(ad_tx, e_ad);
         cmp({lines_oe, ad_oe}, 2'h3);
         @(posedge clock);
      end
      #1 cmp(lines_oe, 0);
   endtask
   task automatic agent(input logic [5:0] c, input logic [2:0] l, input logic [4:0][31:0] s);
      @(posedge clock);
      go <= 1'b1;
      p_code <= c;
      p_len <= l;
      p_seq <= s;
      p_marks <= m;
      @(posedge clock);
      go <= 1'b0;
      repeat (l + 2) @(posedge clock);
   endtask
   task automatic finish_test;
      $display("errors=%0d checks=%0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial clock = 1'b0;
   always #5 clock = ~clock;
   initial begin
      #100000;
      num_errors++;
      finish_test();
   end
   initial begin
      {reg_write, reg_read, go, reg_addr, reg_wdata, p_code, p_len, p_seq} = '0;
      rst = 1'b1;
      {p_marks, m, num_errors, check_count} = 0;
      seed = 88740;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      rd(`REG_CTRL);
      cmp(rv, 1);
      rd(`REG_TX_MARKS);
      cmp(rv, 32'h0000_000F);
      rd(8'hFC);
      cmp(rv, 0);
      foreach (CODES[j]) begin
         code = CODES[j];
         n = nwords(code);
         m = 4'($random(seed));
         addr = $random(seed) & 32'hFFFF_FFF0;
         wr(`REG_TX_ADDR, addr);
         wr(`REG_TX_MARKS, {28'h0, m});
         for (int i = 0; i < n; i++) begin
            w[i] = $random(seed);
            wr(`REG_TX_DATA, w[i]);
         end
         wr(`REG_TX_CMD, {26'h0, code});
         chk_pkt(code, n);
      end
      // Reserved code, then a write with no buffered words
      for (int i = 0; i < 2; i++) begin
         wr(`REG_TX_CMD, i ? 32'h0000_003C : 32'h0000_003F);
         #1 cmp(lines_oe, 0);
         rd(`REG_STATUS);
         cmp(rv[0], 1);
         wr(`REG_STATUS, 32'h0000_001F);
      end
      // Realign: a misaligned two-word write waits one idle cycle
      addr = addr | 32'h0000_0001;
      wr(`REG_CTRL, 32'h0000_0003);
      wr(`REG_TX_ADDR, addr);
      for (int i = 0; i < 2; i++) begin
         wr(`REG_TX_DATA, w[i]);
      end
      wr(`REG_TX_CMD, 32'h0000_0034);
      #1 cmp(lines_oe, 0);
      @(posedge clock);
      chk_pkt(6'h34, 2);
      wr(`REG_CTRL, 32'h0000_0001);
      agent(6'h3C, 3'h5, {w[3], w[2], w[1], w[0], addr});
      rd(`REG_RX_ADDR);
      cmp(rv, addr);
      for (int i = 0; i < 4; i++) begin
         rd(`REG_RX_DATA);
         cmp(rv, w[i]);
      end
      rd(`REG_RX_HEAD);
      cmp(rv, {20'h0, m, 2'h0, 6'h3C});
      agent(6'h12, 3'h2, {96'h0, w[3], w[2]});
      for (int i = 2; i < 4; i++) begin
         rd(`REG_RX_DATA);
         cmp(rv, w[i]);
      end
      agent(6'h3E, 3'h1, {5{32'h0000_0000}});
      rd(`REG_STATUS);
      cmp(rv[1], 1);
      rd(`REG_RX_HEAD);
      cmp(rv[5:0], 6'h12);
      finish_test();
   end
endmodule
